// ==== design/dsad_top.sv ====
// data space access decode: x/y read paths, write lanes, traps
`timescale 1ns/10ps
`default_nettype none
`include "dsad_cfg.svh"
module dsad_top
(
   input  wire logic                  clock,
   input  wire logic                  rstn,
   input  wire logic                  op_valid,
   input  wire logic                  op_mac,
   input  wire logic                  op_write,
   input  wire logic                  op_byte,
   input  wire logic                  op_accwb,
   input  wire logic                  op_wreg,
   input  wire dsad_pkg::dsad_amode_e op_amode,
   input  wire logic [15:0]           op_direct,
   input  wire logic [15:0]           op_wdata,
   input  wire logic [15:0]           dst_old,
   input  wire logic [15:0]           source_work_reg,
   input  wire logic [15:0]           x_pointer_first,
   input  wire logic [15:0]           x_pointer_second,
   input  wire logic [15:0]           y_pointer_first,
   input  wire logic [15:0]           y_pointer_second,
   input  wire logic                  x_mac_sel,
   input  wire logic                  y_mac_sel,
   input  wire dsad_pkg::dsad_amode_e y_amode,
   input  wire logic                  xmod_en,
   input  wire logic [15:0]           xmod_start,
   input  wire logic [15:0]           xmod_end,
   input  wire logic                  ymod_en,
   input  wire logic [15:0]           ymod_start,
   input  wire logic [15:0]           ymod_end,
   input  wire logic                  brev_en,
   input  wire logic [15:0]           brev_step,
   input  wire logic                  stk_push,
   input  wire logic                  stk_pop,
   input  wire dsad_pkg::dsad_pkind_e stk_kind,
   input  wire logic [7:0]            pc_high,
   input  wire logic [7:0]            status_low_byte,
   input  wire logic                  lim_we,
   input  wire logic [15:0]           lim_wdata,
   input  wire logic [15:0]           x_mem_rdata,
   input  wire logic [15:0]           y_mem_rdata,
   output logic      [14:0]           x_mem_addr,
   output logic                       x_mem_rd,
   output logic                       x_mem_we_lo,
   output logic                       x_mem_we_hi,
   output logic      [15:0]           x_mem_wdata,
   output logic      [14:0]           y_mem_addr,
   output logic                       y_mem_rd,
   output logic                       ptr_upd,
   output logic      [15:0]           x_ptr_next,
   output logic      [15:0]           y_ptr_next,
   output logic                       rd_valid,
   output logic      [15:0]           x_rdata,
   output logic      [15:0]           y_rdata,
   output logic                       addr_err_trap,
   output logic                       stack_err_trap,
   output logic      [15:0]           stack_pointer_reg,
   output logic      [15:0]           stack_limit_reg
);
   import dsad_pkg::*;

   function automatic logic in_y(input logic [15:0] a);
      in_y = (a >= `DSAD_Y_BASE) && (a <= `DSAD_Y_LAST);
   endfunction

   function automatic logic impl(input logic [15:0] a);
      impl = (a <= `DSAD_MEM_LAST);
   endfunction

   dsad_top_s   st;
   dsad_top_s   nx;
   logic [15:0] x_ptr;
   logic [15:0] y_ptr;
   logic [15:0] x_ea;
   logic [15:0] y_ea;
   logic [15:0] x_pn;
   logic [15:0] y_pn;
   logic [15:0] stk_ea;
   logic        stk_fault;
   logic        stk_op;
   logic        x_brev;
   logic        wsize;
   logic        misal;
   logic [7:0]  rbyte;

   // mac class reads are bound to their dedicated pointer pairs
   assign x_ptr  = op_mac ? (x_mac_sel ? x_pointer_second : x_pointer_first)
                          : source_work_reg;
   assign y_ptr  = y_mac_sel ? y_pointer_second : y_pointer_first;
   assign x_brev = brev_en && op_write && !op_mac;
   assign stk_op = stk_push || stk_pop;

   dsad_agu u_xagu
   (
      .ptr       (x_ptr),
      .mode      (op_amode),
      .direct    (op_direct),
      .byte_op   (op_byte),
      .mod_en    (xmod_en),
      .mod_start (xmod_start),
      .mod_end   (xmod_end),
      .brev_en   (x_brev),
      .brev_step (brev_step),
      .ea        (x_ea),
      .ptr_next  (x_pn)
   );

   // y only fetches words and never bit-reverses
   dsad_agu u_yagu
   (
      .ptr       (y_ptr),
      .mode      (y_amode),
      .direct    (`DSAD_ZERO),
      .byte_op   (1'b0),
      .mod_en    (ymod_en),
      .mod_start (ymod_start),
      .mod_end   (ymod_end),
      .brev_en   (1'b0),
      .brev_step (`DSAD_ZERO),
      .ea        (y_ea),
      .ptr_next  (y_pn)
   );

   dsad_stack u_stack
   (
      .clock     (clock),
      .rstn      (rstn),
      .push      (stk_push),
      .pop       (stk_pop),
      .lim_we    (lim_we),
      .lim_wdata (lim_wdata),
      .sp        (stack_pointer_reg),
      .lim       (stack_limit_reg),
      .stk_ea    (stk_ea),
      .fault     (stk_fault)
   );

   always_comb
   begin
      nx = st;
      nx.x_rd      = 1'b0;
      nx.x_we_lo   = 1'b0;
      nx.x_we_hi   = 1'b0;
      nx.y_rd      = 1'b0;
      nx.rd_valid  = 1'b0;
      nx.addr_trap = 1'b0;
      nx.stk_trap  = 1'b0;
      nx.ptr_upd   = 1'b0;
      // accumulator write-back is always a full word
      wsize = !op_byte || op_accwb;
      misal = wsize && x_ea[0];
      rbyte = st.x_hi ? x_mem_rdata[15:8] : x_mem_rdata[7:0];
      if (stk_op)
      begin
         nx.x_addr   = stk_ea[15:1];
         nx.x_rd     = stk_pop;
         nx.x_we_lo  = stk_push;
         nx.x_we_hi  = stk_push;
         nx.x_zero   = 1'b0;
         nx.x_byte   = 1'b0;
         nx.x_merge  = 1'b0;
         nx.stk_trap = stk_fault;
         case (stk_kind)
            PK_CALL: nx.x_wdata = {8'h00, pc_high};
            PK_EXC:  nx.x_wdata = {status_low_byte, pc_high};
            default: nx.x_wdata = op_wdata;
         endcase
      end
      else if (op_valid)
      begin
         // full 16-bit byte address, word index on the array
         nx.x_addr    = x_ea[15:1];
         nx.addr_trap = misal;
         nx.ptr_upd   = 1'b1;
         nx.x_ptr_nx  = x_pn;
         nx.y_ptr_nx  = y_pn;
         if (op_write)
         begin
            // writes see x and y as one space, so no y exclusion here
            nx.x_we_lo = impl(x_ea) && !misal && (wsize || !x_ea[0]);
            nx.x_we_hi = impl(x_ea) && !misal && (wsize || x_ea[0]);
            nx.x_wdata = wsize ? op_wdata : {op_wdata[7:0], op_wdata[7:0]};
         end
         else
         begin
            // a misaligned read still completes; the trap comes with the read strobe, a cycle before the data
            nx.x_rd    = 1'b1;
            nx.x_zero  = !impl(x_ea) || (op_mac && in_y(x_ea));
            nx.x_byte  = op_byte;
            nx.x_hi    = x_ea[0];
            nx.x_merge = op_byte && op_wreg;
            nx.dst_hi  = dst_old[15:8];
            if (op_mac)
            begin
               nx.y_rd      = 1'b1;
               nx.y_addr    = y_ea[15:1];
               nx.y_zero    = !in_y(y_ea);
               nx.addr_trap = misal || y_ea[0];
            end
         end
      end
      // arrays answer combinationally while the read strobe stands
      if (st.x_rd || st.y_rd)
      begin
         nx.rd_valid = 1'b1;
         if (st.x_zero)
            nx.x_rdata = st.x_merge ? {st.dst_hi, 8'h00} : `DSAD_ZERO;
         else if (st.x_merge)
            nx.x_rdata = {st.dst_hi, rbyte};
         else if (st.x_byte)
            nx.x_rdata = {8'h00, rbyte};
         else
            nx.x_rdata = x_mem_rdata;
         nx.y_rdata = (st.y_zero || !st.y_rd) ? `DSAD_ZERO : y_mem_rdata;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st <= '0;
      else
         st <= nx;
   end

   assign x_mem_addr     = st.x_addr;
   assign x_mem_rd       = st.x_rd;
   assign x_mem_we_lo    = st.x_we_lo;
   assign x_mem_we_hi    = st.x_we_hi;
   assign x_mem_wdata    = st.x_wdata;
   assign y_mem_addr     = st.y_addr;
   assign y_mem_rd       = st.y_rd;
   assign ptr_upd        = st.ptr_upd;
   assign x_ptr_next     = st.x_ptr_nx;
   assign y_ptr_next     = st.y_ptr_nx;
   assign rd_valid       = st.rd_valid;
   assign x_rdata        = st.x_rdata;
   assign y_rdata        = st.y_rdata;
   assign addr_err_trap  = st.addr_trap;
   assign stack_err_trap = st.stk_trap;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_mac_x_in_y;
      op_valid && op_mac && !op_write && !stk_op && !op_wreg && in_y(x_ea);
   endsequence
   sequence s_zero_x;
      rd_valid && (x_rdata == `DSAD_ZERO);
   endsequence
   property p_mac_x_zero;
      s_mac_x_in_y |-> ##2 s_zero_x;
   endproperty
   a_mac_x_zero: assert property (p_mac_x_zero)
      else $error("mac x read of y space not zero");

   property p_mac_y_zero;
      op_valid && op_mac && !op_write && !stk_op && !in_y(y_ea)
         |-> ##2 (rd_valid && (y_rdata == `DSAD_ZERO));
   endproperty
   a_mac_y_zero: assert property (p_mac_y_zero)
      else $error("mac y read outside y space not zero");

   property p_y_mac_only;
      y_mem_rd |-> $past(op_valid && op_mac && !op_write && !stk_op);
   endproperty
   a_y_mac_only: assert property (p_y_mac_only)
      else $error("y read outside a mac read");

   property p_nonmac_full;
      op_valid && !op_mac && !op_write && !stk_op && impl(x_ea)
         |=> x_mem_rd && (x_mem_addr == $past(x_ea[15:1]));
   endproperty
   a_nonmac_full: assert property (p_nonmac_full)
      else $error("linear x read not issued");

   property p_misal_trap;
      op_valid && !stk_op && !op_byte && x_ea[0] |=> addr_err_trap;
   endproperty
   a_misal_trap: assert property (p_misal_trap)
      else $error("odd word access did not trap");

   property p_misal_nowr;
      op_valid && op_write && !stk_op && !op_byte && x_ea[0]
         |=> !(x_mem_we_lo || x_mem_we_hi);
   endproperty
   a_misal_nowr: assert property (p_misal_nowr)
      else $error("misaligned write not suppressed");

   property p_trap_cause;
      addr_err_trap |-> $past(op_valid && !stk_op);
   endproperty
   a_trap_cause: assert property (p_trap_cause)
      else $error("address trap without an access");

   property p_byte_wr;
      op_valid && op_write && op_byte && !op_accwb && !stk_op && impl(x_ea)
         |=> (x_mem_we_lo != x_mem_we_hi) && (x_mem_we_hi == $past(x_ea[0]));
   endproperty
   a_byte_wr: assert property (p_byte_wr)
      else $error("byte write lane wrong");

   property p_push_step;
      stk_push |=> stack_pointer_reg == $past(stack_pointer_reg) + `DSAD_WSTEP;
   endproperty
   a_push_step: assert property (p_push_step)
      else $error("push did not advance stack pointer by a word");

   sequence s_push_at_lim;
      stk_push && !lim_we && (stack_pointer_reg == stack_limit_reg)
         && (stack_pointer_reg >= `DSAD_SP_FLOOR);
   endsequence
   property p_lim_next;
      s_push_at_lim |=> (!stack_err_trap and (stk_push |=> stack_err_trap));
   endproperty
   a_lim_next: assert property (p_lim_next)
      else $error("stack limit check wrong");

   property p_floor;
      stk_op && (stk_ea < `DSAD_SP_FLOOR) |=> stack_err_trap;
   endproperty
   a_floor: assert property (p_floor)
      else $error("stack underflow did not trap");

   property p_call_hi;
      stk_push && (stk_kind == PK_CALL) |=> (x_mem_wdata >> 8) == `DSAD_ZERO;
   endproperty
   a_call_hi: assert property (p_call_hi)
      else $error("call push upper byte not clear");
endmodule
`default_nettype wire

// ==== design/dsad_cfg.svh ====
// data space access decode: address map and step constants
`ifndef DSAD_CFG_SVH
`define DSAD_CFG_SVH
`define DSAD_Y_BASE    16'h1000
`define DSAD_Y_LAST    16'h17FF
`define DSAD_MEM_LAST  16'h1FFF
`define DSAD_NEAR_MASK 16'h1FFF
`define DSAD_SP_FLOOR  16'h0800
`define DSAD_SP_RST    16'h0800
`define DSAD_LIM_RST   16'h0000
`define DSAD_ZERO      16'h0000
`define DSAD_BSTEP     16'h0001
`define DSAD_WSTEP     16'h0002
`endif

// ==== design/dsad_pkg.sv ====
// data space access decode: shared types
package dsad_pkg;
   typedef enum logic [2:0] {
      AM_IND  = 3'b000,
      AM_INC  = 3'b001,
      AM_DEC  = 3'b010,
      AM_NEAR = 3'b011,
      AM_DIR  = 3'b100
   } dsad_amode_e;
   typedef enum logic [1:0] {
      PK_DATA = 2'b00,
      PK_CALL = 2'b01,
      PK_EXC  = 2'b10
   } dsad_pkind_e;
   typedef struct packed {
      logic [15:0] sp;
      logic [15:0] lim;
   } dsad_stk_s;
   typedef struct packed {
      logic [14:0] x_addr;
      logic        x_rd;
      logic        x_we_lo;
      logic        x_we_hi;
      logic [15:0] x_wdata;
      logic [14:0] y_addr;
      logic        y_rd;
      logic        x_zero;
      logic        y_zero;
      logic        x_byte;
      logic        x_hi;
      logic        x_merge;
      logic [7:0]  dst_hi;
      logic        rd_valid;
      logic [15:0] x_rdata;
      logic [15:0] y_rdata;
      logic        addr_trap;
      logic        stk_trap;
      logic        ptr_upd;
      logic [15:0] x_ptr_nx;
      logic [15:0] y_ptr_nx;
   } dsad_top_s;
endpackage

// ==== design/dsad_agu.sv ====
// address generation: effective address and pointer post-modify
`timescale 1ns/10ps
`default_nettype none
`include "dsad_cfg.svh"
module dsad_agu
(
   input  wire logic [15:0]         ptr,
   input  wire dsad_pkg::dsad_amode_e mode,
   input  wire logic [15:0]         direct,
   input  wire logic                byte_op,
   input  wire logic                mod_en,
   input  wire logic [15:0]         mod_start,
   input  wire logic [15:0]         mod_end,
   input  wire logic                brev_en,
   input  wire logic [15:0]         brev_step,
   output logic      [15:0]         ea,
   output logic      [15:0]         ptr_next
);
   import dsad_pkg::*;

   function automatic logic [15:0] rev16(input logic [15:0] a);
      for (int i = 0; i < 16; i++)
         rev16[i] = a[15 - i];
   endfunction

   logic [15:0] step;

   always_comb
   begin
      step = byte_op ? `DSAD_BSTEP : `DSAD_WSTEP;
      case (mode)
         AM_NEAR: ea = direct & `DSAD_NEAR_MASK;
         AM_DIR:  ea = direct;
         default: ea = ptr;
      endcase
      ptr_next = ptr;
      case (mode)
         AM_INC:
         begin
            // reverse-carry add walks fft order; modulo is off while it runs
            if (brev_en)
               ptr_next = rev16(rev16(ptr) + rev16(brev_step));
            else if (mod_en && (ptr + step > mod_end))
               ptr_next = mod_start;
            else
               ptr_next = ptr + step;
         end
         AM_DEC:
         begin
            if (mod_en && !brev_en && (ptr - step < mod_start))
               ptr_next = mod_end + `DSAD_BSTEP - step;
            else
               ptr_next = ptr - step;
         end
         default: ptr_next = ptr;
      endcase
   end
endmodule
`default_nettype wire

// ==== design/dsad_stack.sv ====
// stack pointer, stack limit and stack error detection
`timescale 1ns/10ps
`default_nettype none
`include "dsad_cfg.svh"
module dsad_stack
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        push,
   input  wire logic        pop,
   input  wire logic        lim_we,
   input  wire logic [15:0] lim_wdata,
   output logic      [15:0] sp,
   output logic      [15:0] lim,
   output logic      [15:0] stk_ea,
   output logic             fault
);
   import dsad_pkg::*;

   dsad_stk_s st;
   dsad_stk_s nx;

   always_comb
   begin
      nx = st;
      // push post-increments, pop pre-decrements; push wins a clash
      stk_ea = push ? st.sp : st.sp - `DSAD_WSTEP;
      if (push)
         nx.sp = st.sp + `DSAD_WSTEP;
      else if (pop)
         nx.sp = st.sp - `DSAD_WSTEP;
      if (lim_we)
         nx.lim = {lim_wdata[15:1], 1'b0};
      // equal to the limit is still legal; only beyond it faults
      fault = (push && (st.sp > st.lim))
         || ((push || pop) && (stk_ea < `DSAD_SP_FLOOR));
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         st.sp  <= `DSAD_SP_RST;
         st.lim <= `DSAD_LIM_RST;
      end
      else
         st <= nx;
   end

   assign sp  = st.sp;
   assign lim = st.lim;
endmodule
`default_nettype wire

// ==== tb/dsad_mem_model.sv ====
// x/y data memory array model answering the access decoder
`timescale 1ns/10ps
`default_nettype none
module dsad_mem_model
(
   input  wire logic        clock,
   input  wire logic [14:0] x_addr,
   input  wire logic        x_rd,
   input  wire logic        we_lo,
   input  wire logic        we_hi,
   input  wire logic [15:0] wdata,
   input  wire logic [14:0] y_addr,
   input  wire logic        y_rd,
   output logic      [15:0] x_rdata,
   output logic      [15:0] y_rdata
);
   logic [15:0] mem [0:32767];
   initial
   begin
      for (int i = 0; i < 32768; i++)
         mem[i] = 16'(i * 7) ^ 16'hA5C3;
   end
   // one shared array: y space is a window of x space, and only the x port writes
   always @(posedge clock)
   begin
      if (we_lo)
         mem[x_addr][7:0] <= wdata[7:0];
      if (we_hi)
         mem[x_addr][15:8] <= wdata[15:8];
   end
   // unstrobed lines show inverted data so a late sample never passes by luck
   assign x_rdata = x_rd ? mem[x_addr] : ~mem[x_addr];
   assign y_rdata = y_rd ? mem[y_addr] : ~mem[y_addr];
endmodule
`default_nettype wire

// ==== tb/dsad_top_tb_top.sv ====
// self-checking bench for the data space access decoder
`timescale 1ns/10ps
`default_nettype none
`include "dsad_cfg.svh"
module dsad_top_tb_top;
   import dsad_pkg::*;
   logic        clock, rstn, op_valid, op_mac, op_write, op_byte, op_accwb, op_wreg;
   logic        x_mac_sel, y_mac_sel, xmod_en, ymod_en, brev_en, stk_push, stk_pop, lim_we;
   dsad_amode_e op_amode, y_amode;
   dsad_pkind_e stk_kind;
   logic [7:0]  pc_high, status_low_byte;
   logic [15:0] op_direct, op_wdata, dst_old, source_work_reg, x_pointer_first;
   logic [15:0] x_pointer_second, y_pointer_first, y_pointer_second, xmod_start, xmod_end;
   logic [15:0] ymod_start, ymod_end, brev_step, lim_wdata, x_mem_rdata, y_mem_rdata;
   logic [14:0] x_mem_addr, y_mem_addr;
   logic        x_mem_rd, x_mem_we_lo, x_mem_we_hi, y_mem_rd, ptr_upd, rd_valid, acc_f;
   logic        addr_err_trap, stack_err_trap;
   logic [15:0] x_mem_wdata, x_ptr_next, y_ptr_next, x_rdata, y_rdata;
   logic [15:0] stack_pointer_reg, stack_limit_reg;
   int          err_count, n_checks, seed, sp_m, lim_m, r;
   logic [15:0] shadow [int];

   dsad_top dut (.clock, .rstn, .op_valid, .op_mac, .op_write, .op_byte, .op_accwb, .op_wreg,
      .op_amode, .op_direct, .op_wdata, .dst_old, .source_work_reg, .x_pointer_first,
      .x_pointer_second, .y_pointer_first, .y_pointer_second, .x_mac_sel, .y_mac_sel,
      .y_amode, .xmod_en, .xmod_start, .xmod_end, .ymod_en, .ymod_start, .ymod_end,
      .brev_en, .brev_step, .stk_push, .stk_pop, .stk_kind, .pc_high, .status_low_byte,
      .lim_we, .lim_wdata, .x_mem_rdata, .y_mem_rdata, .x_mem_addr, .x_mem_rd, .x_mem_we_lo,
      .x_mem_we_hi, .x_mem_wdata, .y_mem_addr, .y_mem_rd, .ptr_upd, .x_ptr_next, .y_ptr_next,
      .rd_valid, .x_rdata, .y_rdata, .addr_err_trap, .stack_err_trap, .stack_pointer_reg,
      .stack_limit_reg);

   dsad_mem_model mem (.clock, .x_addr(x_mem_addr), .x_rd(x_mem_rd), .we_lo(x_mem_we_lo),
      .we_hi(x_mem_we_hi), .wdata(x_mem_wdata), .y_addr(y_mem_addr), .y_rd(y_mem_rd),
      .x_rdata(x_mem_rdata), .y_rdata(y_mem_rdata));

   initial
   begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic in_y(input logic [15:0] a);
      return a >= `DSAD_Y_BASE && a <= `DSAD_Y_LAST;
   endfunction

   // expected word at a byte address; writes seen so far live in shadow
   function automatic logic [15:0] mem_rd(input logic [15:0] ea);
      int w;
      w = ea[15:1];
      if (ea > `DSAD_MEM_LAST)
         return 16'h0000;
      return shadow.exists(w) ? shadow[w] : 16'(w * 7) ^ 16'hA5C3;
   endfunction

   // waits the taking edge, drops one-cycle requests, lets the edge's updates land
   task automatic take();
      @(posedge clock);
      op_valid <= 1'h0;
      stk_push <= 1'h0;
      stk_pop <= 1'h0;
      lim_we <= 1'h0;
      #1;
   endtask

   task automatic xacc(input logic wr, input logic byt, input dsad_amode_e md,
                       input logic [15:0] p, input logic [15:0] wd);
      logic [15:0] ea, pn, w;
      logic        tr, ok;
      ea = (md == AM_NEAR) ? (p & `DSAD_NEAR_MASK) : p;
      tr = !byt && ea[0];
      ok = !tr && ea <= `DSAD_MEM_LAST;
      pn = byt ? `DSAD_BSTEP : `DSAD_WSTEP;
      pn = (md == AM_INC) ? p + pn : p - pn;
      // modulo settings driven at the edge before the call land only at this edge
      @(posedge clock);
      if (xmod_en && md == AM_INC && p == xmod_end)
         pn = xmod_start;
      op_valid <= 1'h1;
      op_mac <= acc_f;
      op_accwb <= acc_f;
      op_write <= wr;
      op_byte <= byt;
      op_amode <= md;
      source_work_reg <= p;
      // accumulator write-back is a mac access, addressed through the x pointers
      x_pointer_first <= p;
      x_pointer_second <= p;
      op_direct <= p;
      op_wdata <= wd;
      take();
      chk("addr_err_trap", addr_err_trap, tr);
      chk("y_mem_rd", y_mem_rd, 1'h0);
      chk("ptr_upd", ptr_upd, 1'h1);
      chk("x_mem_rd", x_mem_rd, !wr);
      chk("x_mem_we_lo", x_mem_we_lo, wr && ok && !(byt && ea[0]));
      chk("x_mem_we_hi", x_mem_we_hi, wr && ok && !(byt && !ea[0]));
      if (!wr || ok)
         chk("x_mem_addr", x_mem_addr, ea[15:1]);
      if ((md == AM_INC || md == AM_DEC) && !tr)
         chk("x_ptr_next", x_ptr_next, pn);
      w = mem_rd({ea[15:1], 1'h0});
      if (wr && ok)
      begin
         w = byt ? (ea[0] ? {wd[7:0], w[7:0]} : {w[15:8], wd[7:0]}) : wd;
         shadow[ea[15:1]] = w;
         chk("x_mem_wdata", x_mem_wdata, byt ? {2{wd[7:0]}} : wd);
      end
      if (byt)
         w = {op_wreg ? dst_old[15:8] : 8'h00, ea[0] ? w[15:8] : w[7:0]};
      @(posedge clock);
      #1;
      chk("addr_err_trap", addr_err_trap, 1'h0);
      chk("rd_valid", rd_valid, !wr);
      if (!wr && !tr)
         chk("x_rdata", x_rdata, w);
   endtask

   task automatic mac(input logic [15:0] xp, input logic [15:0] yp, input logic s);
      logic [15:0] xe, ye, yn;
      xe = in_y(xp) ? 16'h0000 : mem_rd(xp);
      ye = in_y(yp) ? mem_rd(yp) : 16'h0000;
      @(posedge clock);
      yn = (ymod_en && yp == ymod_end) ? ymod_start : yp + `DSAD_WSTEP;
      op_valid <= 1'h1;
      op_mac <= 1'h1;
      op_write <= 1'h0;
      op_byte <= 1'h0;
      op_amode <= AM_IND;
      y_amode <= AM_INC;
      x_mac_sel <= s;
      y_mac_sel <= !s;
      // the unselected pointers aim at valid data so a wrong pick shows
      x_pointer_first <= s ? 16'h0002 : xp;
      x_pointer_second <= s ? xp : 16'h0002;
      y_pointer_first <= s ? yp : 16'h1002;
      y_pointer_second <= s ? 16'h1002 : yp;
      take();
      if (!in_y(xp))
         chk("x_mem_rd", x_mem_rd, 1'h1);
      if (in_y(yp))
         chk("y_mem_addr", {1'h0, y_mem_addr}, {1'h0, yp[15:1]});
      chk("y_ptr_next", y_ptr_next, yn);
      chk("y_mem_rd", y_mem_rd, 1'h1);
      @(posedge clock);
      #1;
      chk("x_rdata", x_rdata, xe);
      chk("y_rdata", y_rdata, ye);
   endtask

   task automatic stk(input logic psh, input dsad_pkind_e k);
      logic [15:0] d, a;
      logic        tr;
      r = $random(seed);
      d = (k == PK_CALL) ? {8'h00, r[7:0]} : (k == PK_EXC) ? r[15:0] : r[31:16];
      a = psh ? 16'(sp_m) : 16'(sp_m - 2);
      tr = psh ? (sp_m > lim_m || sp_m < `DSAD_SP_FLOOR) : (a < `DSAD_SP_FLOOR);
      @(posedge clock);
      pc_high <= r[7:0];
      status_low_byte <= r[15:8];
      op_wdata <= r[31:16];
      stk_kind <= k;
      stk_push <= psh;
      stk_pop <= !psh;
      take();
      chk("stack_err_trap", stack_err_trap, tr);
      chk("stack_pointer_reg", stack_pointer_reg, psh ? a + 16'h0002 : a);
      chk("x_mem_addr", x_mem_addr, a[15:1]);
      chk("x_mem_we_hi", x_mem_we_hi, psh);
      chk("x_mem_we_lo", x_mem_we_lo, psh);
      chk("x_mem_rd", x_mem_rd, !psh);
      if (psh)
      begin
         shadow[a[15:1]] = d;
         chk("x_mem_wdata", x_mem_wdata, d);
      end
      sp_m = psh ? sp_m + 2 : sp_m - 2;
      @(posedge clock);
      #1;
      chk("stack_err_trap", stack_err_trap, 1'h0);
      if (!psh)
         chk("x_rdata", x_rdata, mem_rd(a));
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      err_count++;
      wrap_up();
   end

   initial
   begin
      seed = 32'h739DFEDF;
      {rstn, op_valid, op_mac, op_write, op_byte, op_accwb, op_wreg, x_mac_sel} = '0;
      {y_mac_sel, xmod_en, ymod_en, brev_en, stk_push, stk_pop, lim_we, acc_f} = '0;
      {pc_high, status_low_byte, op_direct, op_wdata, dst_old, source_work_reg} = '0;
      {x_pointer_first, x_pointer_second, y_pointer_first, y_pointer_second} = '0;
      {xmod_start, xmod_end, ymod_start, ymod_end, brev_step, lim_wdata} = '0;
      op_amode = AM_IND;
      y_amode = AM_IND;
      stk_kind = PK_DATA;
      err_count = 0;
      n_checks = 0;
      sp_m = `DSAD_SP_RST;
      repeat (5) @(posedge clock);
      rstn <= 1'h1;
      @(posedge clock);
      #1;
      chk("stack_pointer_reg", stack_pointer_reg, `DSAD_SP_RST);
      chk("stack_limit_reg", stack_limit_reg, `DSAD_LIM_RST);
      for (int i = 0; i < 60; i++)
      begin
         @(posedge clock);
         op_wreg <= 1'($random(seed));
         dst_old <= 16'($random(seed));
         xacc(1'($random(seed)), 1'($random(seed)), dsad_amode_e'(i % 5),
              16'($random(seed)) & 16'h3FFF, 16'($random(seed)));
      end
      xacc(1'h1, 1'h1, AM_IND, 16'h1001, 16'h00C5);
      xacc(1'h0, 1'h1, AM_IND, 16'h1001, 16'h0000);
      xacc(1'h0, 1'h0, AM_DIR, 16'h2000, 16'h0000);
      xacc(1'h1, 1'h0, AM_INC, 16'h1FFF, 16'h1234);
      acc_f = 1'h1;
      xacc(1'h1, 1'h0, AM_IND, 16'h1400, 16'hBEEF);
      acc_f = 1'h0;
      @(posedge clock);
      xmod_en <= 1'h1;
      xmod_start <= 16'h0100;
      xmod_end <= 16'h0106;
      xacc(1'h0, 1'h0, AM_INC, 16'h0106, 16'h0000);
      @(posedge clock);
      xmod_en <= 1'h0;
      brev_en <= 1'h1;
      brev_step <= 16'h0010;
      xacc(1'h0, 1'h0, AM_INC, 16'h0200, 16'h0000);
      @(posedge clock);
      brev_en <= 1'h0;
      mac(16'h0800, 16'h1100, 1'h0);
      mac(16'h0A00, 16'h17FE, 1'h1);
      mac(16'h1200, 16'h1400, 1'h0);
      mac(16'h0400, 16'h0600, 1'h1);
      mac(16'h3000, 16'h1000, 1'h0);
      @(posedge clock);
      ymod_en <= 1'h1;
      ymod_start <= 16'h1000;
      ymod_end <= 16'h1010;
      mac(16'h0800, 16'h1010, 1'h1);
      @(posedge clock);
      lim_we <= 1'h1;
      lim_wdata <= 16'h0807;
      take();
      chk("stack_limit_reg", stack_limit_reg, 16'h0806);
      lim_m = 16'h0806;
      // two idle cycles before the first stack push after a limit write: this wait and the one inside stk
      @(posedge clock);
      for (int i = 0; i < 5; i++)
         stk(1'h1, dsad_pkind_e'(i % 3));
      for (int i = 0; i < 6; i++)
         stk(1'h0, PK_DATA);
      stk(1'h1, PK_DATA);
      wrap_up();
   end
endmodule
`default_nettype wire
